// file: pkg/hfp_pkg.sv
// Constants shared by the host-side FIFO handshake controller.
// Assumes one system clock of 125 MHz driving producer and consumer logic.
package hfp_pkg;
  localparam int unsigned CLK_PERIOD_PS = 8000;
  // Least strobe width that the FIFO recognises, in ns
  localparam int unsigned STROBE_MIN_NS = 20;
  localparam int unsigned STROBE_MIN_CYC =
    ((STROBE_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS) < 1 ? 1 :
    ((STROBE_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam int unsigned WORD_WIDTH = 4;
  localparam int unsigned FIFO_DEPTH = 16;
  localparam int unsigned FIFO_CAPACITY = 64;
  // Pulse synchroniser states, coded as the two stages B and C
  localparam logic [1:0] SYNC_IDLE = 2'h0;
  localparam logic [1:0] SYNC_HIGH = 2'h2;
  localparam logic [1:0] SYNC_LOW = 2'h3;
  localparam logic [1:0] SYNC_BACK = 2'h1;
endpackage

// file: src/hfp_pulse_sync.sv
// Two-stage pulse synchroniser: one strobe per rising edge of a flag.
// Assumes the flag is asynchronous to clk_in; any gating is applied by the caller
// ahead of this module so that the first stage sees it first.
`timescale 1ns/1ps
module hfp_pulse_sync #(
  parameter int unsigned MIN_CYC = hfp_pkg::STROBE_MIN_CYC
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic flag_in,
  output logic strobe_out,
  output logic busy_out
);
  initial begin
    if (MIN_CYC < 1 || MIN_CYC > 255) begin
      $error("hfp_pulse_sync: MIN_CYC out of range");
    end
  end

  logic stage_a;
  logic stage_b;
  logic next_stage_a;
  logic next_stage_b;

  // Stage A is read only by stage B, so metastability never reaches the strobe
  always_comb begin
    next_stage_a = flag_in;
    next_stage_b = stage_a;
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      stage_a <= 1'b0;
      stage_b <= 1'b0;
    end else begin
      stage_a <= next_stage_a;
      stage_b <= next_stage_b;
    end
  end

  // Strobe is B-delayed edge: high from state 10 (SYNC_HIGH) through held extension
  logic stage_c;
  logic stretch;
  logic next_strobe;
  logic [7:0] width;
  logic [7:0] next_width;
  always_comb begin
    next_strobe = 1'b0;
    next_width = 8'h00;
    if ({stage_b, stage_c} == hfp_pkg::SYNC_HIGH) begin
      next_strobe = 1'b1;
      next_width = 8'h01;
    end else if (strobe_out && width < 8'(MIN_CYC)) begin
      next_strobe = 1'b1;
      next_width = width + 8'h01;
    end
  end
  assign stretch = strobe_out;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      stage_c <= 1'b0;
      strobe_out <= 1'b0;
      width <= 8'h00;
    end else begin
      stage_c <= stage_b;
      strobe_out <= next_strobe;
      width <= next_width;
    end
  end
  assign busy_out = stretch | stage_b;
endmodule

// file: src/hfp_buffer.sv
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock; width and depth are parameters, depth a power of two.
`timescale 1ns/1ps
module hfp_buffer #(
  parameter int unsigned WIDTH = hfp_pkg::WORD_WIDTH,
  parameter int unsigned DEPTH = hfp_pkg::FIFO_DEPTH
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);
  localparam int unsigned AW = $clog2(DEPTH);
  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin
      $error("hfp_buffer: bad WIDTH or DEPTH");
    end
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  logic [AW:0] next_wr_ptr;
  logic [AW:0] next_rd_ptr;
  logic do_wr;
  logic do_rd;

  assign in_ready_out = (wr_ptr - rd_ptr) != (AW+1)'(DEPTH);
  assign out_valid_out = wr_ptr != rd_ptr;
  assign out_data_out = mem[rd_ptr[AW-1:0]];
  assign do_wr = in_valid_in && in_ready_out;
  assign do_rd = out_valid_out && out_ready_in;

  always_comb begin
    next_wr_ptr = do_wr ? wr_ptr + (AW+1)'(1) : wr_ptr;
    next_rd_ptr = do_rd ? rd_ptr + (AW+1)'(1) : rd_ptr;
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
    end
  end

  always_ff @(posedge clk_in) begin
    if (do_wr) begin
      mem[wr_ptr[AW-1:0]] <= in_data_in;
    end
  end
endmodule

// file: src/hfp_host.sv
// Host controller for a strobe-handshake FIFO: producer and consumer ends.
// Assumes the FIFO pins are asynchronous to clk_in; words to write arrive
// from user logic through a buffer, read words leave on a registered port.
// Overview of operation
// - Cascade: output valid drives next shift-in, next ready drives shift-out.
// - Each side forms strobes from its flag with logic on its own clock.
// - Any gating of a flag happens before the first synchronising flop.
// - Exactly one strobe of minimum width per flag rising edge.
// - Two-stage shift register states 00 idle, 10 high, 11 low, 01 back.
// - Synchroniser clock at least twice the word shift rate.
// - Shift-out strobe lasts at least one full clock period.
// - Shortest strobe emitted must still be recognised by the FIFO.
// - Flag change at a clock edge still yields a wide enough strobe.
// - Consumer latches FIFO output word on shift-out strobe rise.
`timescale 1ns/1ps
module hfp_host #(
  parameter int unsigned WIDTH = hfp_pkg::WORD_WIDTH,
  parameter int unsigned DEPTH = hfp_pkg::FIFO_DEPTH,
  parameter int unsigned MIN_CYC = hfp_pkg::STROBE_MIN_CYC
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic wr_valid_in,
  output logic wr_ready_out,
  input wire logic [WIDTH-1:0] wr_data_in,
  output logic rd_valid_out,
  output logic [WIDTH-1:0] rd_data_out,
  input wire logic rd_enable_in,
  input wire logic input_ready_flag_in,
  input wire logic output_valid_flag_in,
  output logic shift_in_out,
  output logic [WIDTH-1:0] fifo_data_out,
  output logic shift_out_out,
  input wire logic [WIDTH-1:0] fifo_data_in
);
  initial begin
    if (WIDTH < 4 || WIDTH > 5) begin
      $error("hfp_host: WIDTH must be 4 or 5");
    end
  end

  typedef enum logic [1:0] {HFP_W_IDLE, HFP_W_STROBE, HFP_W_WAIT} hfp_wstate_t;

  logic buf_valid;
  logic buf_ready;
  logic [WIDTH-1:0] buf_data;
  logic gated_ir;
  logic si_pulse;
  logic si_busy;
  logic gated_or;
  logic so_pulse;
  logic so_busy;

  hfp_buffer #(
    .WIDTH(WIDTH),
    .DEPTH(DEPTH)
  ) u_buf (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .in_valid_in(wr_valid_in),
    .in_ready_out(wr_ready_out),
    .in_data_in(wr_data_in),
    .out_valid_out(buf_valid),
    .out_ready_in(buf_ready),
    .out_data_out(buf_data)
  );

  logic data_staged_n;
  // Flag gated by our own wish to write, before the first flop
  assign gated_ir = input_ready_flag_in & buf_valid & ~data_staged_n;

  hfp_pulse_sync #(
    .MIN_CYC(MIN_CYC)
  ) u_si_sync (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .flag_in(gated_ir),
    .strobe_out(si_pulse),
    .busy_out(si_busy)
  );

  // Producer: put word on pins, then strobe; pop buffer when strobe ends
  hfp_wstate_t wstate;
  hfp_wstate_t next_wstate;
  logic [WIDTH-1:0] next_fifo_data;
  logic next_staged_n;
  always_comb begin
    next_wstate = wstate;
    next_fifo_data = fifo_data_out;
    next_staged_n = data_staged_n;
    buf_ready = 1'b0;
    unique case (wstate)
      HFP_W_IDLE: begin
        next_fifo_data = buf_data;
        if (si_pulse) begin
          // Block at once: the flag returns at the strobe fall, before the pop
          next_staged_n = 1'b1;
          next_wstate = HFP_W_STROBE;
        end
      end
      HFP_W_STROBE: begin
        if (!si_pulse) begin
          buf_ready = 1'b1;
          next_wstate = HFP_W_WAIT;
        end
      end
      HFP_W_WAIT: begin
        // Rearm only once the old flag edge has left the synchroniser
        if (!si_busy) begin
          next_staged_n = 1'b0;
          next_wstate = HFP_W_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wstate <= HFP_W_IDLE;
      fifo_data_out <= '0;
      data_staged_n <= 1'b0;
    end else begin
      wstate <= next_wstate;
      fifo_data_out <= next_fifo_data;
      data_staged_n <= next_staged_n;
    end
  end
  assign shift_in_out = si_pulse;

  // Consumer: gate valid flag with the read enable before syncing
  // Same flag-to-strobe path as a cascade, where valid feeds the next shift-in
  assign gated_or = output_valid_flag_in & rd_enable_in;
  hfp_pulse_sync #(
    .MIN_CYC(MIN_CYC)
  ) u_so_sync (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .flag_in(gated_or),
    .strobe_out(so_pulse),
    .busy_out(so_busy)
  );
  assign shift_out_out = so_pulse;

  // Data pins are asynchronous, but stable since the strobe fall before
  logic [WIDTH-1:0] rd_s1;
  logic [WIDTH-1:0] rd_s2;
  logic so_q;
  logic next_rd_valid;
  logic [WIDTH-1:0] next_rd_data;
  always_comb begin
    next_rd_valid = 1'b0;
    next_rd_data = rd_data_out;
    if (so_pulse && !so_q) begin
      next_rd_valid = 1'b1;
      next_rd_data = rd_s2;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rd_s1 <= '0;
      rd_s2 <= '0;
      so_q <= 1'b0;
      rd_valid_out <= 1'b0;
      rd_data_out <= '0;
    end else begin
      rd_s1 <= fifo_data_in;
      rd_s2 <= rd_s1;
      so_q <= so_pulse;
      rd_valid_out <= next_rd_valid;
      rd_data_out <= next_rd_data;
    end
  end
endmodule

// file: testbench/hfp_fifo_model.sv
// Behavioural 64-word strobe FIFO facing the host controller.
// Assumes strobes come from the host; flags go straight back.
`timescale 1ns/1ps
module hfp_fifo_model (
  input wire logic put_in,
  input wire logic take_in,
  input wire logic [3:0] d_in,
  output logic [3:0] q_out,
  output logic rdy_out,
  output logic vld_out
);
  logic [3:0] mem [64];
  logic [6:0] wp = 7'h0, rp = 7'h0;
  logic pq = 1'b0, tq = 1'b0, pb = 1'b0, tb = 1'b0;
  // Flags fall during a strobe, so each word needs a fresh flag edge
  assign rdy_out = wp - rp != 7'h40 && !pb;
  assign vld_out = wp != rp && !tb;
  always @(put_in, take_in) begin
    if (put_in && !pq && rdy_out) begin
      mem[wp[5:0]] = d_in;
      pb = 1'b1;
    end
    if (!put_in && pq && pb) begin
      if (wp == rp && !tb) q_out = mem[wp[5:0]];
      wp = wp + 7'h1;
      pb = 1'b0;
    end
    if (take_in && !tq && vld_out) begin
      rp = rp + 7'h1;
      tb = 1'b1;
    end
    // An empty part shows no stale word
    if (!take_in && tq && tb) begin
      q_out = wp != rp ? mem[rp[5:0]] : ~q_out;
      tb = 1'b0;
    end
    pq = put_in;
    tq = take_in;
  end
endmodule

// file: testbench/hfp_host_properties.sv
// Checker on the host controller's strobe and read-back ports.
// Assumes one clock; bound into hfp_host below.
`timescale 1ns/1ps
module hfp_host_chk #(
  parameter int unsigned WIDTH = hfp_pkg::WORD_WIDTH,
  parameter int unsigned MIN_CYC = hfp_pkg::STROBE_MIN_CYC
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic rd_enable_in,
  input wire logic input_ready_flag_in,
  input wire logic output_valid_flag_in,
  input wire logic shift_in_out,
  input wire logic shift_out_out,
  input wire logic rd_valid_out,
  input wire logic [WIDTH-1:0] rd_data_out,
  input wire logic [WIDTH-1:0] fifo_data_out,
  input wire logic [WIDTH-1:0] fifo_data_in
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  logic [7:0] put_n, take_n;
  logic lo_seen;
  // Flag must drop between shift-ins, else one edge made two strobes
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      put_n <= 8'h0;
      take_n <= 8'h0;
      lo_seen <= 1'b1;
    end else begin
      put_n <= shift_in_out ? put_n + 8'h1 : 8'h0;
      take_n <= shift_out_out ? take_n + 8'h1 : 8'h0;
      lo_seen <= $rose(shift_in_out) ? 1'b0 : lo_seen | !input_ready_flag_in;
    end
  end
  put_width_a: assert property ($fell(shift_in_out) |-> put_n >= MIN_CYC)
    else $error("short shift-in");
  take_width_a: assert property ($fell(shift_out_out) |-> take_n >= MIN_CYC)
    else $error("short shift-out");
  put_once_a: assert property ($rose(shift_in_out) |-> lo_seen)
    else $error("two shift-ins for one edge");
  put_gate_a: assert property ($rose(shift_in_out) |->
    $past(input_ready_flag_in, 3)) else $error("shift-in without ready");
  take_gate_a: assert property ($rose(shift_out_out) |->
    $past(output_valid_flag_in, 3) && $past(rd_enable_in, 3)) else $error("bad shift-out");
  read_pulse_a: assert property ($rose(shift_out_out) |->
    ##1 rd_valid_out ##1 !rd_valid_out) else $error("read pulse wrong");
  read_word_a: assert property (rd_valid_out |->
    rd_data_out == $past(fifo_data_in, 3)) else $error("read word wrong");
  put_hold_a: assert property ($rose(shift_in_out) |=>
    $stable(fifo_data_out)[*2]) else $error("word moved under shift-in");
endmodule
bind hfp_host hfp_host_chk #(.WIDTH(WIDTH), .MIN_CYC(MIN_CYC)) chk_u (.clk_in(clk_in),
  .rst_n_in(rst_n_in), .rd_enable_in(rd_enable_in), .input_ready_flag_in(input_ready_flag_in),
  .output_valid_flag_in(output_valid_flag_in), .shift_in_out(shift_in_out),
  .shift_out_out(shift_out_out), .rd_valid_out(rd_valid_out), .rd_data_out(rd_data_out),
  .fifo_data_out(fifo_data_out), .fifo_data_in(fifo_data_in));

// file: testbench/handshake_fifo_pulse_sync_test.sv
// Bench: host controller driving a behavioural strobe FIFO.
// Assumes default parameters: 4-bit words, 16-word buffer.
`timescale 1ns/1ps
module handshake_fifo_pulse_sync_test;
  logic clk = 1'b0, rst_n = 1'b0, wv = 1'b0, re = 1'b0;
  logic [3:0] wd = 4'h0;
  logic wr, rv, pt, tk, rdy, vld;
  logic [3:0] rd, fo, fi;
  int err_total = 0, total_checks = 0;
  logic [3:0] rx [$];
  always #4 clk = ~clk;
  hfp_host dut_u (.clk_in(clk), .rst_n_in(rst_n), .wr_valid_in(wv), .wr_ready_out(wr),
    .wr_data_in(wd), .rd_valid_out(rv), .rd_data_out(rd), .rd_enable_in(re),
    .input_ready_flag_in(rdy), .output_valid_flag_in(vld), .shift_in_out(pt),
    .fifo_data_out(fo), .shift_out_out(tk), .fifo_data_in(fi));
  hfp_fifo_model fifo_u (.put_in(pt), .take_in(tk), .d_in(fo), .q_out(fi), .rdy_out(rdy),
    .vld_out(vld));
  always @(negedge clk) if (rv === 1'b1) rx.push_back(rd);
  task automatic wrap_up();
    if (err_total == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input bit ok, input string m);
    total_checks++;
    if (!ok) begin
      err_total++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask
  task automatic push(input logic [3:0] w, output bit ok);
    int n;
    n = 0;
    @(negedge clk);
    wv = 1'b1;
    wd = w;
    while (wr !== 1'b1 && n < 200) begin
      @(negedge clk);
      n++;
    end
    ok = wr === 1'b1;
    if (ok) @(posedge clk);
    else wv = 1'b0;
  endtask
  task automatic drain(input int cnt, input int base);
    int n;
    n = 0;
    @(negedge clk);
    wv = 1'b0;
    re = 1'b1;
    while (rx.size() < cnt && n < 3000) begin
      @(negedge clk);
      n++;
    end
    chk(rx.size() == cnt, "word count");
    foreach (rx[i]) chk(rx[i] === 4'(base + i), "word order");
    rx.delete();
  endtask
  task automatic t_reset();
    chk(wr === 1'b1 && pt === 1'b0 && tk === 1'b0 && rv === 1'b0, "reset");
  endtask
  // Reads held off until both FIFO and buffer refuse, then all drained
  task automatic t_fill();
    int acc;
    bit ok;
    acc = 0;
    ok = 1'b1;
    while (ok && acc < 99) begin
      push(4'(acc), ok);
      acc += int'(ok);
    end
    chk(acc == int'(hfp_pkg::FIFO_CAPACITY + hfp_pkg::FIFO_DEPTH) && rdy === 1'b0 &&
      vld === 1'b1 && rx.size() == 0, "fill");
    drain(acc, 0);
    chk(vld === 1'b0 && wr === 1'b1, "empty");
  endtask
  task automatic t_gate();
    bit ok;
    @(negedge clk);
    re = 1'b0;
    for (int i = 0; i < 3; i++) push(4'(9 + i), ok);
    // Last push leaves valid up; drop it so the word is taken only once
    @(negedge clk);
    wv = 1'b0;
    repeat (60) @(negedge clk);
    chk(rx.size() == 0 && vld === 1'b1, "read while off");
    drain(3, 9);
  endtask
  initial begin
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    t_reset();
    t_fill();
    t_gate();
    wrap_up();
  end
  // Twenty thousand cycles, several times the expected run
  initial begin
    #160000;
    err_total++;
    wrap_up();
  end
endmodule
